//--- hdl/prefetch_unit.sv
// instruction prefetch unit with its ahb-lite register slave
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "prefetch_defs.svh"

// Overview of operation
// - while enabled, fetch instructions ahead in blocks of four or eight dwords
// - pick largest burst from burst length and, in cache mode, cache line
// - if bursts of four dwords are impossible, prefetching turns itself off
// - every memory move instruction except the no-flush one flushes the buffer
// - the no-flush memory move leaves the buffer intact
// - every store flushes the buffer unless its no-flush option is set
// - any write to the script pointer flushes the buffer
// - a taken transfer control instruction flushes the buffer
// - the flush control bit flushes the buffer and clears itself
// - two-dword opcode bursts only while prefetching is off
module prefetch_unit
    import prefetch_pkg::*;
#(
    parameter int DEPTH = 8
)
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    input  wire logic        i_fetch_req,
    input  wire logic [31:0] i_fetch_addr,
    output logic             o_fetch_valid,
    output logic      [31:0] o_fetch_data,
    input  wire logic        i_memory_move_instr,
    input  wire logic        i_noflush_memory_move_instr,
    input  wire logic        i_store_exec,
    input  wire logic        i_store_noflush,
    input  wire logic        i_xfer_taken,
    output logic             o_dma_req,
    output logic      [31:0] o_dma_addr,
    output logic      [3:0]  o_dma_len,
    input  wire logic        i_dma_valid,
    input  wire logic [31:0] i_dma_data,
    input  wire logic        i_dma_done,
    output logic      [31:0] o_script_ptr,
    output logic             o_sp_load
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic           wr_pend_reg;
    logic [7:0]     wr_addr_reg;
    logic           rd_wait_reg;
    logic [7:0]     rd_addr_reg;
    logic [31:0]    rd_val;
    logic           bus_take;
    logic           sp_wr;
    logic [1:0]     burst_code_reg;
    logic           opfetch_en_reg;
    logic           pf_enable_reg;
    logic           flush_bit_reg;
    logic [7:0]     cache_line_reg;
    logic           cache_en_reg;
    logic [3:0]     block_words;
    logic           pf_active;
    logic           flush_now;
    pf_state_type   state_reg;
    logic [31:0]    buf_base_reg;
    logic [3:0]     buf_cnt_reg;
    logic [31:0]    fill_base_reg;
    logic [3:0]     fill_cnt_reg;
    logic           stale_reg;
    logic           req_pend_reg;
    logic [31:0]    req_addr_reg;
    logic           refill_reg;
    logic [2:0]     rd_idx_reg;
    logic [31:0]    hit_diff;
    logic           req_hit;
    logic [31:0]    mem_rdata;
    logic           mem_we;

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------
    // largest usable block: 8, 4, or 0 when four is not reachable
    function automatic logic [3:0] pick_block(input logic [1:0] code,
                                              input logic       cen,
                                              input logic [7:0] cls);
        logic [7:0] lim;
        lim = 8'h02;
        case (burst_code_type'(code))
            BURST_2:  lim = 8'h02;
            BURST_4:  lim = 8'h04;
            BURST_8:  lim = 8'h08;
            default:  lim = 8'h10;
        endcase
        if (cen && cls < lim)
        begin
            lim = cls;
        end
        if (lim >= 8'h08)
            return `PF_LARGE_BLOCK;
        else if (lim >= 8'h04)
            return `PF_SMALL_BLOCK;
        else
            return 4'h0;
    endfunction : pick_block

    // a dword address lies inside the valid part of the buffer
    function automatic logic in_buffer(input logic [31:0] a,
                                       input logic [31:0] base,
                                       input logic [3:0]  cnt);
        logic [31:0] d;
        d = a - base;
        return (cnt != 4'h0) && (a[1:0] == 2'h0)
               && (d[31:2] < {26'h0, cnt});
    endfunction : in_buffer

    // ------------------------------------------------------------------
    // ahb-lite slave: writes zero-wait, reads one wait state
    // ------------------------------------------------------------------
    assign bus_take = i_hsel && i_hready && i_htrans[1];
    assign sp_wr    = wr_pend_reg && (wr_addr_reg == `PF_SCRIPT_PTR_OFFSET);

    // address phase capture
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            rd_wait_reg <= 1'b0;
            rd_addr_reg <= 8'h00;
        end
        else
        begin
            wr_pend_reg <= bus_take && i_hwrite;
            rd_wait_reg <= bus_take && !i_hwrite;
            if (bus_take)
            begin
                wr_addr_reg <= i_haddr[7:0];
                rd_addr_reg <= i_haddr[7:0];
            end
        end
    end

    // read wait state lets a write just before a read land first
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            o_hreadyout <= 1'b1;
            o_hrdata    <= 32'h0000_0000;
            o_hresp     <= 1'b0;
        end
        else
        begin
            o_hreadyout <= !(bus_take && !i_hwrite);
            if (rd_wait_reg)
            begin
                o_hrdata <= rd_val;
            end
        end
    end

    // read mux; unmapped offsets read as zero
    always_comb
    begin
        rd_val = 32'h0000_0000;
        if (rd_addr_reg == `PF_SCRIPT_PTR_OFFSET)
            rd_val = o_script_ptr;
        else if (rd_addr_reg == `PF_DMA_MODE_OFFSET)
        begin
            rd_val[`PF_MODE_BURST_MSB:`PF_MODE_BURST_LSB] = burst_code_reg;
            rd_val[`PF_MODE_OPFETCH_BIT] = opfetch_en_reg;
        end
        else if (rd_addr_reg == `PF_DMA_CONTROL_OFFSET)
        begin
            rd_val[`PF_CTRL_ENABLE_BIT] = pf_enable_reg;
            rd_val[`PF_CTRL_FLUSH_BIT]  = flush_bit_reg;
        end
        else if (rd_addr_reg == `PF_CACHE_CTRL_OFFSET)
        begin
            rd_val[`PF_CACHE_LINE_MSB:0] = cache_line_reg;
            rd_val[`PF_CACHE_EN_BIT]     = cache_en_reg;
        end
        else if (rd_addr_reg == `PF_STATUS_OFFSET)
        begin
            rd_val[`PF_STAT_CNT_MSB:0]   = buf_cnt_reg;
            rd_val[`PF_STAT_ACTIVE_BIT]  = pf_active;
            rd_val[`PF_STAT_FILL_BIT]    = (state_reg == ST_FILL);
        end
    end

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            burst_code_reg <= `PF_BURST_CODE_RESET;
            opfetch_en_reg <= 1'b0;
            pf_enable_reg  <= 1'b0;
            cache_line_reg <= `PF_CACHE_LINE_RESET;
            cache_en_reg   <= 1'b0;
        end
        else if (wr_pend_reg)
        begin
            if (wr_addr_reg == `PF_DMA_MODE_OFFSET)
            begin
                burst_code_reg <=
                    i_hwdata[`PF_MODE_BURST_MSB:`PF_MODE_BURST_LSB];
                opfetch_en_reg <= i_hwdata[`PF_MODE_OPFETCH_BIT];
            end
            else if (wr_addr_reg == `PF_DMA_CONTROL_OFFSET)
                pf_enable_reg <= i_hwdata[`PF_CTRL_ENABLE_BIT];
            else if (wr_addr_reg == `PF_CACHE_CTRL_OFFSET)
            begin
                cache_line_reg <= i_hwdata[`PF_CACHE_LINE_MSB:0];
                cache_en_reg   <= i_hwdata[`PF_CACHE_EN_BIT];
            end
        end
    end

    // flush bit: a new set wins over the self-clear
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
            flush_bit_reg <= 1'b0;
        else if (wr_pend_reg && wr_addr_reg == `PF_DMA_CONTROL_OFFSET
                 && i_hwdata[`PF_CTRL_FLUSH_BIT])
            flush_bit_reg <= 1'b1;
        else
            flush_bit_reg <= 1'b0;
    end

    // script pointer, with a load pulse for the sequencer
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            o_script_ptr <= `PF_SCRIPT_PTR_RESET;
            o_sp_load    <= 1'b0;
        end
        else
        begin
            o_sp_load <= sp_wr;
            if (sp_wr)
                o_script_ptr <= i_hwdata;
        end
    end

    // ------------------------------------------------------------------
    // burst choice and flush sources
    // ------------------------------------------------------------------
    assign block_words = pick_block(burst_code_reg, cache_en_reg,
                                    cache_line_reg);
    assign pf_active   = pf_enable_reg && (block_words != 4'h0);
    // no-flush move is deliberately absent here
    assign flush_now = i_memory_move_instr
                     || (i_store_exec && !i_store_noflush)
                     || sp_wr
                     || i_xfer_taken
                     || flush_bit_reg;
    assign hit_diff = req_addr_reg - buf_base_reg;
    assign req_hit  = in_buffer(req_addr_reg, buf_base_reg, buf_cnt_reg);
    assign mem_we   = (state_reg == ST_FILL) && i_dma_valid
                      && (fill_cnt_reg < DEPTH[3:0]);

    // ------------------------------------------------------------------
    // pending instruction request from the sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            req_pend_reg <= 1'b0;
            req_addr_reg <= 32'h0000_0000;
        end
        else if (i_fetch_req)
        begin
            req_pend_reg <= 1'b1;
            req_addr_reg <= i_fetch_addr;
        end
        else if (state_reg == ST_READ)
            req_pend_reg <= 1'b0;
    end

    // ------------------------------------------------------------------
    // prefetch engine
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            state_reg     <= ST_IDLE;
            buf_base_reg  <= 32'h0000_0000;
            buf_cnt_reg   <= 4'h0;
            fill_base_reg <= 32'h0000_0000;
            fill_cnt_reg  <= 4'h0;
            stale_reg     <= 1'b0;
            refill_reg    <= 1'b0;
            rd_idx_reg    <= 3'h0;
            o_dma_req     <= 1'b0;
            o_dma_addr    <= 32'h0000_0000;
            o_dma_len     <= 4'h0;
            o_fetch_valid <= 1'b0;
            o_fetch_data  <= 32'h0000_0000;
        end
        else
        begin
            o_dma_req     <= 1'b0;
            o_fetch_valid <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    if (flush_now)
                    begin
                        buf_cnt_reg <= 4'h0;
                        refill_reg  <= 1'b0;
                    end
                    else if (req_pend_reg && req_hit)
                    begin
                        rd_idx_reg <= hit_diff[4:2];
                        state_reg  <= ST_READ;
                    end
                    else if (req_pend_reg || (refill_reg && pf_active))
                    begin
                        // misses go first; a refill continues the window
                        o_dma_req     <= 1'b1;
                        o_dma_addr    <= req_pend_reg ? req_addr_reg
                            : buf_base_reg + {26'h0, buf_cnt_reg, 2'h0};
                        fill_base_reg <= req_pend_reg ? req_addr_reg
                            : buf_base_reg + {26'h0, buf_cnt_reg, 2'h0};
                        if (pf_active)
                            o_dma_len <= block_words;
                        else if (opfetch_en_reg)
                            o_dma_len <= `PF_OPFETCH_BURST;
                        else
                            o_dma_len <= `PF_SINGLE_FETCH;
                        fill_cnt_reg  <= 4'h0;
                        stale_reg     <= 1'b0;
                        refill_reg    <= 1'b0;
                        state_reg     <= ST_FILL;
                    end
                end
                ST_FILL:
                begin
                    if (mem_we)
                        fill_cnt_reg <= fill_cnt_reg + 4'h1;
                    if (flush_now)
                    begin
                        stale_reg  <= 1'b1;
                        refill_reg <= 1'b0;
                    end
                    if (i_dma_done)
                    begin
                        // a flush during the burst discards it entirely
                        if (stale_reg || flush_now)
                            buf_cnt_reg <= 4'h0;
                        else
                        begin
                            buf_base_reg <= fill_base_reg;
                            buf_cnt_reg  <= fill_cnt_reg
                                            + {3'h0, mem_we};
                        end
                        state_reg <= ST_IDLE;
                    end
                end
                ST_READ:
                begin
                    o_fetch_valid <= 1'b1;
                    o_fetch_data  <= mem_rdata;
                    if (flush_now)
                    begin
                        buf_cnt_reg <= 4'h0;
                        refill_reg  <= 1'b0;
                    end
                    else if ({1'b0, rd_idx_reg} == buf_cnt_reg - 4'h1)
                        refill_reg <= pf_active;
                    state_reg <= ST_IDLE;
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // buffer storage
    // ------------------------------------------------------------------
    prefetch_store #(
        .WIDTH (32),
        .DEPTH (DEPTH),
        .AW    (3)
    ) u_store (
        .i_ref_clk (i_ref_clk),
        .i_we      (mem_we),
        .i_waddr   (fill_cnt_reg[2:0]),
        .i_wdata   (i_dma_data),
        .i_raddr   (hit_diff[4:2]), // leads the read state a cycle
        .o_rdata   (mem_rdata)
    );

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    a_block_size: assert property (o_dma_req && $past(pf_active) |->
        (o_dma_len == 4'h4 || o_dma_len == 4'h8))
        else $error("prefetch block is not four or eight dwords");
    a_self_off: assert property (o_dma_req &&
        $past(block_words == 4'h0) |-> o_dma_len < 4'h4)
        else $error("prefetch active without 4-dword bursts");
    a_move_flush: assert property (i_memory_move_instr &&
        state_reg != ST_FILL |=> buf_cnt_reg == 4'h0)
        else $error("memory move did not flush");
    a_nf_move_keep: assert property (i_noflush_memory_move_instr
        && !flush_now && state_reg == ST_IDLE |=> $stable(buf_cnt_reg))
        else $error("no-flush move disturbed the buffer");
    a_store_flush: assert property (i_store_exec && !i_store_noflush
        && state_reg != ST_FILL |=> buf_cnt_reg == 4'h0)
        else $error("store did not flush");
    a_sp_flush: assert property (sp_wr && state_reg == ST_IDLE
        |=> buf_cnt_reg == 4'h0 && o_sp_load)
        else $error("pointer write did not flush");
    a_xfer_flush: assert property (i_xfer_taken && state_reg
        != ST_FILL |=> buf_cnt_reg == 4'h0 && !refill_reg)
        else $error("taken transfer did not flush");
    a_flush_clear: assert property ($rose(flush_bit_reg) |=>
        !flush_bit_reg || $past(wr_pend_reg))
        else $error("flush bit did not clear itself");
    a_opfetch_off: assert property (o_dma_req &&
        o_dma_len == 4'h2 |-> !$past(pf_active))
        else $error("two-dword burst while prefetching");
    a_hit_serve: assert property (state_reg == ST_IDLE &&
        req_pend_reg && req_hit && !flush_now |=> !o_dma_req
        ##1 o_fetch_valid)
        else $error("buffer hit not served in two cycles");

endmodule : prefetch_unit

//--- hdl/prefetch_defs.svh
// register offsets, field positions and reset values of the prefetch unit
`ifndef PREFETCH_DEFS_SVH
`define PREFETCH_DEFS_SVH

// ----------------------------------------------------------------------
// register byte offsets (haddr[7:0])
// ----------------------------------------------------------------------
`define PF_SCRIPT_PTR_OFFSET  8'h2c
`define PF_DMA_MODE_OFFSET    8'h38
`define PF_DMA_CONTROL_OFFSET 8'h3c
`define PF_CACHE_CTRL_OFFSET  8'h40
`define PF_STATUS_OFFSET      8'h44

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PF_MODE_BURST_LSB     6
`define PF_MODE_BURST_MSB     7
`define PF_MODE_OPFETCH_BIT   1
`define PF_CTRL_ENABLE_BIT    2
`define PF_CTRL_FLUSH_BIT     5
`define PF_CACHE_LINE_MSB     7
`define PF_CACHE_EN_BIT       8
`define PF_STAT_CNT_MSB       3
`define PF_STAT_ACTIVE_BIT    4
`define PF_STAT_FILL_BIT      5

// ----------------------------------------------------------------------
// reset values and burst sizes in dwords
// ----------------------------------------------------------------------
`define PF_SCRIPT_PTR_RESET   32'h0000_0000
`define PF_BURST_CODE_RESET   2'h0
`define PF_CACHE_LINE_RESET   8'h00
`define PF_SMALL_BLOCK        4'h4
`define PF_LARGE_BLOCK        4'h8
`define PF_OPFETCH_BURST      4'h2
`define PF_SINGLE_FETCH       4'h1

`endif

//--- hdl/prefetch_pkg.sv
// types shared by the prefetch unit files
package prefetch_pkg;

    // ------------------------------------------------------------------
    // sequencer of the prefetch engine
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FILL,
        ST_READ
    } pf_state_type;

    // programmed burst length code: 2, 4, 8 or 16 dwords
    typedef enum logic [1:0] {
        BURST_2,
        BURST_4,
        BURST_8,
        BURST_16
    } burst_code_type;

endpackage : prefetch_pkg

//--- hdl/prefetch_store.sv
// small instruction store with registered read data
`timescale 1ns/1ps

module prefetch_store
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8,
    parameter int AW    = 3
)
(
    input  wire logic             i_ref_clk,
    input  wire logic             i_we,
    input  wire logic [AW-1:0]    i_waddr,
    input  wire logic [WIDTH-1:0] i_wdata,
    input  wire logic [AW-1:0]    i_raddr,
    output logic      [WIDTH-1:0] o_rdata
);

    logic [WIDTH-1:0] mem_reg [DEPTH];

    // ------------------------------------------------------------------
    // write port
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_we)
        begin
            mem_reg[i_waddr] <= i_wdata;
        end
    end

    // read data come out of a register, one cycle after the address
    always_ff @(posedge i_ref_clk)
    begin
        o_rdata <= mem_reg[i_raddr];
    end

endmodule : prefetch_store

//--- tb/dma_engine_model.sv
// behavioural dma engine answering the prefetch unit's bursts
`timescale 1ns/1ps

module dma_engine_model
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    input  wire logic        i_dma_req,
    input  wire logic [31:0] i_dma_addr,
    input  wire logic [3:0]  i_dma_len,
    output logic             o_dma_valid,
    output logic      [31:0] o_dma_data,
    output logic             o_dma_done
);
    logic [31:0] addr_reg;
    logic [3:0]  left_reg;
    logic        gap_reg;
    logic        slow_reg;

    // ascending dwords; every other burst idles a cycle between dwords
    always_ff @(posedge i_ref_clk)
    begin
        o_dma_valid <= 1'b0;
        o_dma_done  <= 1'b0;
        o_dma_data  <= ~o_dma_data; // idle bus shows the inverse of the previous cycle's data
        if (i_rst)
        begin
            left_reg <= 4'h0;
            slow_reg <= 1'b0;
            gap_reg  <= 1'b0;
        end
        else if (i_dma_req)
        begin
            addr_reg <= i_dma_addr;
            left_reg <= i_dma_len;
            gap_reg  <= slow_reg;
            slow_reg <= ~slow_reg;
        end
        else if (left_reg != 4'h0 && gap_reg)
            gap_reg <= 1'b0;
        else if (left_reg != 4'h0)
        begin
            o_dma_valid <= 1'b1;
            o_dma_data  <= addr_reg ^ 32'h5a5a_0000;
            o_dma_done  <= (left_reg == 4'h1);
            addr_reg    <= addr_reg + 32'h4;
            left_reg    <= left_reg - 4'h1;
            gap_reg     <= ~slow_reg;
        end
    end
endmodule : dma_engine_model

//--- tb/test_instruction_prefetch_unit.sv
// self-checking bench of the instruction prefetch unit
`timescale 1ns/1ps
`include "prefetch_defs.svh"

module test_instruction_prefetch_unit
    import prefetch_pkg::*;
;
    logic        i_ref_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        hsel = 1'b0, hwrite = 1'b0, freq = 1'b0, mem_mv = 1'b0;
    logic        nfm = 1'b0, st = 1'b0, stnf = 1'b0, xfer = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, faddr = 32'h0;
    logic [31:0] base = 32'h1000;
    logic        hready, hresp, fvalid, dreq, dvalid, ddone, spl;
    logic [31:0] hrdata, fdata, daddr, ddata, sp;
    logic [3:0]  dlen;
    int          errors = 0, comparisons = 0, dma_cnt = 0;

    always #2.5 i_ref_clk = ~i_ref_clk;

    prefetch_unit i_dut (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
        .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_fetch_req(freq), .i_fetch_addr(faddr), .o_fetch_valid(fvalid),
        .o_fetch_data(fdata), .i_memory_move_instr(mem_mv),
        .i_noflush_memory_move_instr(nfm), .i_store_exec(st),
        .i_store_noflush(stnf), .i_xfer_taken(xfer),
        .o_dma_req(dreq), .o_dma_addr(daddr), .o_dma_len(dlen),
        .i_dma_valid(dvalid), .i_dma_data(ddata), .i_dma_done(ddone),
        .o_script_ptr(sp), .o_sp_load(spl));

    dma_engine_model i_dma (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_dma_req(dreq),
        .i_dma_addr(daddr), .i_dma_len(dlen), .o_dma_valid(dvalid),
        .o_dma_data(ddata), .o_dma_done(ddone));

    // count burst requests seen on the dma side
    always @(posedge i_ref_clk)
        if (dreq === 1'b1)
            dma_cnt <= dma_cnt + 1;

    // ------------------------------------------------------------------
    // bus, fetch and compare helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // single ahb-lite word transfer, held until hready is sampled high
    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        hsel   <= 1'b1;
        @(posedge i_ref_clk);
        while (!hready) @(posedge i_ref_clk);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        @(posedge i_ref_clk);
        while (!hready) @(posedge i_ref_clk);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask : ahb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask : wr

    // one instruction dword; reports whether a bus burst was needed
    task automatic fetch(input logic [31:0] a, output logic miss);
        int n;
        n = dma_cnt;
        freq  <= 1'b1;
        faddr <= a;
        @(posedge i_ref_clk);
        freq <= 1'b0;
        repeat (300) if (fvalid !== 1'b1) @(posedge i_ref_clk);
        chk({31'h0, fvalid}, 32'h1);
        chk(fdata, a ^ 32'h5a5a_0000);
        miss = (dma_cnt != n);
    endtask : fetch

    task automatic size_case(input burst_code_type c, input logic opf,
        input logic [8:0] cache, input logic en, input logic [3:0] len);
        logic m;
        wr(`PF_DMA_MODE_OFFSET, {24'h0, c, 4'h0, opf, 1'b0});
        wr(`PF_CACHE_CTRL_OFFSET, {23'h0, cache});
        wr(`PF_DMA_CONTROL_OFFSET, {29'h0, en, 2'h0});
        base = base + 32'h100;
        fetch(base, m);
        chk({31'h0, m}, 32'h1);
        chk({28'h0, dlen}, {28'h0, len});
        chk(daddr, base);
    endtask : size_case

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] x;
        ahb(1'b0, `PF_SCRIPT_PTR_OFFSET, 32'h0, x);
        chk(x, `PF_SCRIPT_PTR_RESET);
        ahb(1'b0, `PF_DMA_CONTROL_OFFSET, 32'h0, x);
        chk(x, 32'h0);
        wr(8'h80, 32'hffff_ffff);
        ahb(1'b0, 8'h80, 32'h0, x);
        chk(x, 32'h0);
    endtask : t_reset

    task automatic t_sizes();
        size_case(BURST_8, 1'b0, 9'h000, 1'b1, 4'h8);
        size_case(BURST_4, 1'b0, 9'h000, 1'b1, 4'h4);
        size_case(BURST_16, 1'b0, 9'h104, 1'b1, 4'h4);
        size_case(BURST_2, 1'b0, 9'h000, 1'b1, 4'h1);
        size_case(BURST_16, 1'b0, 9'h102, 1'b1, 4'h1);
        size_case(BURST_2, 1'b1, 9'h000, 1'b0, 4'h2);
        size_case(BURST_8, 1'b1, 9'h000, 1'b1, 4'h8);
    endtask : t_sizes

    // each flush source, then a fetch that would otherwise hit
    task automatic t_flush();
        logic        m;
        logic [31:0] x;
        size_case(BURST_8, 1'b0, 9'h000, 1'b1, 4'h8);
        for (int k = 0; k < 7; k++)
        begin
            base = base + 32'h100;
            fetch(base, m);
            case (k)
                0: mem_mv <= 1'b1;
                1: nfm <= 1'b1;
                2: st <= 1'b1;
                3: {st, stnf} <= 2'h3;
                4: xfer <= 1'b1;
                5: wr(`PF_SCRIPT_PTR_OFFSET, base);
                default: wr(`PF_DMA_CONTROL_OFFSET, 32'h24);
            endcase
            @(posedge i_ref_clk);
            chk({31'h0, spl}, {31'h0, k == 5});
            {mem_mv, nfm, st, stnf, xfer} <= 5'h0;
            @(posedge i_ref_clk);
            fetch(base + 32'h4, m);
            chk({31'h0, m}, {31'h0, k != 1 && k != 3});
            if (k == 5)
                chk(sp, base);
        end
        ahb(1'b0, `PF_DMA_CONTROL_OFFSET, 32'h0, x);
        chk(x, 32'h4);
    endtask : t_flush

    // drain a whole block; the next block must follow on its own
    task automatic t_refill();
        logic m;
        int   n;
        base = base + 32'h100;
        for (int i = 0; i < 8; i++)
        begin
            fetch(base + 32'(4 * i), m);
            chk({31'h0, m}, {31'h0, i == 0});
        end
        n = dma_cnt;
        repeat (50) if (dma_cnt == n) @(posedge i_ref_clk);
        chk(daddr, base + 32'h20);
        fetch(base + 32'h20, m);
        chk({31'h0, m}, 32'h0);
    endtask : t_refill

    task automatic end_sim();
        if (errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    initial
    begin
        repeat (3) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        @(posedge i_ref_clk);
        t_reset();
        t_sizes();
        t_flush();
        t_refill();
        end_sim();
    end

    // watchdog well beyond the few hundred cycles the tests need
    initial
    begin
        #100000;
        errors++;
        end_sim();
    end
endmodule : test_instruction_prefetch_unit
